// ===== rtl/tcm_channel.sv
// Functional notes
// - Bridge on only when enabled and module detected
// - Idle mode drives zero motor voltage
// - Idle still computes primary position from calibration
// - Position calibration entered only from idle
// - Position calibration repeats until request changes; a control calibration request keeps it repeating
// - Idle request aborts calibration at once
// - Control request waits for pass end
// - Control calibration returns straight to idle
// - Control entered from idle, tracks setpoint
// - Control left only toward idle
// - Mode in force reported apart from request
// - Swap flag exchanges primary and secondary inputs
// - Swap flag applies at next capture
// - Capture latches calibration inputs and position
// - Bridge driven by PWM at set frequency
// - Setpoint is percent of calibrated range
// - Bridge fault suspends bridge until cleared
// - Detection needs enable, slot occupied, power
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "tcm_cfg.svh"

module tcm_channel #(
  parameter int unsigned CAL_PHASE_CYC = `TCM_CAL_PHASE_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        slot_occupied_i,
  input  wire logic        ext_power_ok_i,
  input  wire logic        bridge_fault_i,
  input  wire logic [11:0] analog1_i,
  input  wire logic [11:0] analog2_i,
  output logic             bridge_en_o,
  output logic             bridge_pwm_o,
  output logic             bridge_dir_o,
  output logic [1:0]       mode_status_o,
  output logic             module_detected_o
);

  // ========================================================================
  // Helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  function automatic logic [11:0] clip_sub(input logic [11:0] a, input logic [11:0] b);
    return (a > b) ? 12'(a - b) : 12'h000;
  endfunction : clip_sub

  // ========================================================================
  // Pin synchronisers
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  logic       slot_s;
  logic       power_s;
  logic       fault_s;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end else begin
      pin_meta_r <= {bridge_fault_i, ext_power_ok_i, slot_occupied_i};
      pin_sync_r <= pin_meta_r;
    end
  end
  assign slot_s  = pin_sync_r[0];
  assign power_s = pin_sync_r[1];
  assign fault_s = pin_sync_r[2];

  // ========================================================================
  // Register file
  logic [5:0]  ctrl_r;
  logic [15:0] freq_r;
  logic [6:0]  setpt_r;
  logic [11:0] calin_lo_r;
  logic [11:0] calin_hi_r;
  logic [11:0] calout_lo_r;
  logic [11:0] calout_hi_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [31:0] wr_ctrl;
  logic [31:0] wr_freq;
  logic [31:0] wr_setpt;
  logic [31:0] wr_calin;
  logic        wr_go;
  logic        chan_en;
  logic        mod_en;
  logic        cap;
  tcm_pkg::tcm_mode_e req;

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign avs_readdata_o    = rdata_r;
  // Writes land at the acknowledged edge, where the master sees waitrequest low
  assign wr_go    = avs_write_i & ack_r;
  assign wr_ctrl  = be_merge({26'h0, ctrl_r}, avs_writedata_i, avs_byteenable_i);
  assign wr_freq  = be_merge({16'h0, freq_r}, avs_writedata_i, avs_byteenable_i);
  assign wr_setpt = be_merge({25'h0, setpt_r}, avs_writedata_i, avs_byteenable_i);
  assign wr_calin = be_merge({4'h0, calin_hi_r, 4'h0, calin_lo_r}, avs_writedata_i,
                             avs_byteenable_i);
  assign chan_en  = ctrl_r[`TCM_CTRL_CHAN_EN];
  assign mod_en   = ctrl_r[`TCM_CTRL_MOD_EN];
  assign cap      = ctrl_r[`TCM_CTRL_CAPTURE];
  assign req      = tcm_pkg::tcm_mode_e'(ctrl_r[`TCM_CTRL_REQ_LO +: 2]);

  // One wait cycle per access keeps the read mux off the bus path
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_r     <= `TCM_RST_CTRL;
      freq_r     <= `TCM_RST_FREQ;
      setpt_r    <= `TCM_RST_SETPT;
      calin_lo_r <= `TCM_RST_CAL_LO;
      calin_hi_r <= `TCM_RST_CAL_HI;
    end else if (wr_go) begin
      case (avs_address_i & 5'h1c)
        `TCM_OFS_CTRL:  ctrl_r  <= wr_ctrl[5:0];
        `TCM_OFS_FREQ:  freq_r  <= wr_freq[15:0];
        `TCM_OFS_SETPT: setpt_r <= (wr_setpt[6:0] > 7'h64) ? 7'h64 : wr_setpt[6:0];
        `TCM_OFS_CALIN: begin
          calin_lo_r <= wr_calin[11:0];
          calin_hi_r <= wr_calin[`TCM_HI_LSB +: 12];
        end
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Sensors, presence, position
  logic        swap_use_r;
  logic [11:0] cap_lo_r;
  logic [11:0] cap_hi_r;
  logic [11:0] cap_prim_r;
  logic [11:0] prim;
  logic [11:0] sec;
  logic        detected_r;
  logic [11:0] pos_rel_r;

  assign prim = swap_use_r ? analog2_i : analog1_i;
  assign sec  = swap_use_r ? analog1_i : analog2_i;

  // Capture is a level: everything is re-latched every cycle it stays set
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      swap_use_r <= 1'b0;
      cap_lo_r   <= `TCM_RST_CAL_LO;
      cap_hi_r   <= `TCM_RST_CAL_HI;
      cap_prim_r <= 12'h000;
    end else if (cap) begin
      swap_use_r <= ctrl_r[`TCM_CTRL_SWAP];
      cap_lo_r   <= calin_lo_r;
      cap_hi_r   <= calin_hi_r;
      cap_prim_r <= prim;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      detected_r <= 1'b0;
      pos_rel_r  <= 12'h000;
    end else begin
      detected_r <= mod_en & slot_s & power_s;
      pos_rel_r  <= clip_sub(prim, calout_lo_r);
    end
  end
  assign module_detected_o = detected_r;

  // ========================================================================
  // Mode sequencer
  tcm_pkg::tcm_state_e state_r;
  logic        ccal_hold_r;
  logic [23:0] cnt_r;
  logic        phase_r;
  logic        pass_done;

  assign pass_done = phase_r && (cnt_r == 24'(CAL_PHASE_CYC - 1));

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_r <= tcm_pkg::TCM_ST_IDLE;
    end else begin
      case (state_r)
        tcm_pkg::TCM_ST_IDLE: begin
          case (req)
            tcm_pkg::TCM_MODE_PCAL: state_r <= tcm_pkg::TCM_ST_PCAL;
            tcm_pkg::TCM_MODE_CCAL: begin
              state_r <= ccal_hold_r ? tcm_pkg::TCM_ST_IDLE : tcm_pkg::TCM_ST_CCAL;
            end
            tcm_pkg::TCM_MODE_CTRL: state_r <= tcm_pkg::TCM_ST_CTRL;
            default:                state_r <= tcm_pkg::TCM_ST_IDLE;
          endcase
        end
        tcm_pkg::TCM_ST_PCAL: begin
          if (req == tcm_pkg::TCM_MODE_IDLE) begin
            state_r <= tcm_pkg::TCM_ST_IDLE;
          end else if (req == tcm_pkg::TCM_MODE_CTRL && pass_done) begin
            state_r <= tcm_pkg::TCM_ST_CTRL;
          end else begin
            state_r <= tcm_pkg::TCM_ST_PCAL;
          end
        end
        tcm_pkg::TCM_ST_CCAL: state_r <= tcm_pkg::TCM_ST_IDLE;
        tcm_pkg::TCM_ST_CTRL: begin
          if (req == tcm_pkg::TCM_MODE_IDLE) begin
            state_r <= tcm_pkg::TCM_ST_IDLE;
          end else begin
            state_r <= tcm_pkg::TCM_ST_CTRL;
          end
        end
        default: state_r <= tcm_pkg::TCM_ST_IDLE;
      endcase
    end
  end

  // A held request re-enters only once withdrawn, so the status never flickers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ccal_hold_r <= 1'b0;
    end else if (state_r == tcm_pkg::TCM_ST_CCAL) begin
      ccal_hold_r <= 1'b1;
    end else if (req != tcm_pkg::TCM_MODE_CCAL) begin
      ccal_hold_r <= 1'b0;
    end
  end

  always_comb begin
    case (state_r)
      tcm_pkg::TCM_ST_PCAL: mode_status_o = tcm_pkg::TCM_MODE_PCAL;
      tcm_pkg::TCM_ST_CCAL: mode_status_o = tcm_pkg::TCM_MODE_CCAL;
      tcm_pkg::TCM_ST_CTRL: mode_status_o = tcm_pkg::TCM_MODE_CTRL;
      default:              mode_status_o = tcm_pkg::TCM_MODE_IDLE;
    endcase
  end

  // ========================================================================
  // Calibration pass: open sweep then close sweep, tracking the extremes
  logic [11:0] min_r;
  logic [11:0] max_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_r   <= 24'h0;
      phase_r <= 1'b0;
      min_r   <= 12'h000;
      max_r   <= 12'h000;
    end else if (state_r != tcm_pkg::TCM_ST_PCAL || pass_done) begin
      cnt_r   <= 24'h0;
      phase_r <= 1'b0;
      min_r   <= cap_prim_r;
      max_r   <= cap_prim_r;
    end else begin
      if (cnt_r == 24'(CAL_PHASE_CYC - 1)) begin
        cnt_r   <= 24'h0;
        phase_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 24'h1;
      end
      if (prim < min_r) begin
        min_r <= prim;
      end
      if (prim > max_r) begin
        max_r <= prim;
      end
    end
  end

  // Results are clamped into the captured expected range
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      calout_lo_r <= `TCM_RST_CAL_LO;
      calout_hi_r <= `TCM_RST_CAL_HI;
    end else if (state_r == tcm_pkg::TCM_ST_PCAL && pass_done) begin
      calout_lo_r <= (min_r < cap_lo_r) ? cap_lo_r : min_r;
      calout_hi_r <= (max_r > cap_hi_r) ? cap_hi_r : max_r;
    end
  end

  // ========================================================================
  // Position loop and PWM
  logic [11:0] span;
  logic [28:0] scaled;
  logic [12:0] target;
  logic [12:0] err;
  logic [12:0] err_mag;
  logic [7:0]  duty;
  logic        dir;
  logic [24:0] acc_r;
  logic [24:0] acc_sum;
  logic        active;
  logic        pwm_r;
  logic        dir_r;
  logic        bridge_en_r;

  assign span    = clip_sub(calout_hi_r, calout_lo_r);
  assign scaled  = 29'(span * setpt_r * 10'(`TCM_PCT_MUL));
  assign target  = 13'(calout_lo_r) + 13'(scaled[28:16]);
  assign err     = 13'(target - 13'(prim));
  assign err_mag = err[12] ? 13'(-err) : err;
  assign active  = state_r == tcm_pkg::TCM_ST_PCAL || state_r == tcm_pkg::TCM_ST_CTRL;
  assign acc_sum = acc_r + 25'(freq_r);

  always_comb begin
    if (state_r == tcm_pkg::TCM_ST_PCAL) begin
      duty = `TCM_CAL_DUTY;
      dir  = ~phase_r;
    end else if ((err_mag >> `TCM_KP_SHIFT) > 13'h0ff) begin
      duty = 8'hff;
      dir  = ~err[12];
    end else begin
      duty = 8'(err_mag >> `TCM_KP_SHIFT);
      dir  = ~err[12];
    end
  end

  // Phase accumulator wraps once per PWM period at the set rate in Hz
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      acc_r <= 25'h0;
    end else if (acc_sum >= 25'(`TCM_CLK_HZ)) begin
      acc_r <= 25'(acc_sum - 25'(`TCM_CLK_HZ));
    end else begin
      acc_r <= acc_sum;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pwm_r       <= 1'b0;
      dir_r       <= 1'b0;
      bridge_en_r <= 1'b0;
    end else begin
      pwm_r       <= active && (acc_r < 25'(duty * 17'(`TCM_DUTY_STEP)));
      dir_r       <= dir;
      bridge_en_r <= chan_en && detected_r && !fault_s;
    end
  end
  assign bridge_en_o  = bridge_en_r;
  assign bridge_pwm_o = pwm_r;
  assign bridge_dir_o = dir_r;

  // ========================================================================
  // Read mux
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h0;
    end else if (avs_read_i && !ack_r) begin
      case (avs_address_i & 5'h1c)
        `TCM_OFS_CTRL:   rdata_r <= {26'h0, ctrl_r};
        `TCM_OFS_STATUS: rdata_r <= {26'h0, fault_s, swap_use_r, bridge_en_r,
                                     detected_r, mode_status_o};
        `TCM_OFS_FREQ:   rdata_r <= {16'h0, freq_r};
        `TCM_OFS_SETPT:  rdata_r <= {25'h0, setpt_r};
        `TCM_OFS_CALIN:  rdata_r <= {4'h0, calin_hi_r, 4'h0, calin_lo_r};
        `TCM_OFS_CALOUT: rdata_r <= {4'h0, calout_hi_r, 4'h0, calout_lo_r};
        `TCM_OFS_POS:    rdata_r <= {4'h0, sec, 4'h0, pos_rel_r};
        default:         rdata_r <= 32'h0;
      endcase
    end
  end

  // ========================================================================
  // Checks
  chk_bridge_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    bridge_en_o |-> $past(chan_en) && $past(detected_r))
    else $error("bridge enabled without enable and presence");
  chk_fault_stop: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    fault_s |=> !bridge_en_o)
    else $error("bridge stayed enabled during fault");
  chk_idle_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == tcm_pkg::TCM_ST_IDLE) |=> !bridge_pwm_o)
    else $error("motor driven while idle");
  chk_pcal_entry: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(state_r == tcm_pkg::TCM_ST_PCAL) |-> $past(state_r == tcm_pkg::TCM_ST_IDLE))
    else $error("position calibration entered from non-idle");
  chk_pcal_repeat: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == tcm_pkg::TCM_ST_PCAL && pass_done && req == tcm_pkg::TCM_MODE_PCAL)
    |=> state_r == tcm_pkg::TCM_ST_PCAL && cnt_r == 24'h0 && !phase_r)
    else $error("calibration pass not restarted");
  chk_pcal_abort: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == tcm_pkg::TCM_ST_PCAL && req == tcm_pkg::TCM_MODE_IDLE)
    |=> mode_status_o == tcm_pkg::TCM_MODE_IDLE)
    else $error("idle request did not abort calibration");
  chk_pcal_finish: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == tcm_pkg::TCM_ST_PCAL && req == tcm_pkg::TCM_MODE_CTRL && !pass_done)
    |=> state_r == tcm_pkg::TCM_ST_PCAL)
    else $error("control entered before pass end");
  chk_ccal_return: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == tcm_pkg::TCM_ST_CCAL) |=> state_r == tcm_pkg::TCM_ST_IDLE)
    else $error("control calibration did not return to idle");
  chk_ccal_once: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == tcm_pkg::TCM_ST_IDLE && ccal_hold_r) |=> state_r != tcm_pkg::TCM_ST_CCAL)
    else $error("control calibration re-entered without a new request");
  chk_ctrl_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_r == tcm_pkg::TCM_ST_CTRL && req != tcm_pkg::TCM_MODE_IDLE)
    |=> state_r == tcm_pkg::TCM_ST_CTRL)
    else $error("control left without idle request");
  chk_swap_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !cap |=> $stable(swap_use_r))
    else $error("sensor swap changed without capture");
  chk_detect: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    module_detected_o |-> $past(mod_en) && $past(slot_s) && $past(power_s))
    else $error("module detected without enable, slot and power");

endmodule : tcm_channel
`default_nettype wire

// ===== shared/tcm_cfg.svh
`ifndef TCM_CFG_SVH
`define TCM_CFG_SVH
// ==========================================================================
// Clock and timing
`define TCM_CLK_HZ          25000000
`define TCM_CAL_PHASE_MS    200
`define TCM_CAL_PHASE_CYC   (`TCM_CAL_PHASE_MS * (`TCM_CLK_HZ / 1000))
`define TCM_DUTY_STEP       (`TCM_CLK_HZ / 256)
`define TCM_CAL_DUTY        8'hc0
`define TCM_KP_SHIFT        2
`define TCM_PCT_MUL         655
// ==========================================================================
// Register byte offsets
`define TCM_OFS_CTRL        5'h00
`define TCM_OFS_STATUS      5'h04
`define TCM_OFS_FREQ        5'h08
`define TCM_OFS_SETPT       5'h0c
`define TCM_OFS_CALIN       5'h10
`define TCM_OFS_CALOUT      5'h14
`define TCM_OFS_POS         5'h18
// ==========================================================================
// Field positions
`define TCM_CTRL_CHAN_EN    0
`define TCM_CTRL_MOD_EN     1
`define TCM_CTRL_SWAP       2
`define TCM_CTRL_CAPTURE    3
`define TCM_CTRL_REQ_LO     4
`define TCM_ST_DETECTED     2
`define TCM_ST_BRIDGE_EN    3
`define TCM_ST_SWAP_USE     4
`define TCM_ST_FAULT        5
`define TCM_HI_LSB          16
// ==========================================================================
// Reset values
`define TCM_RST_CTRL        6'h00
`define TCM_RST_FREQ        16'h03e8
`define TCM_RST_SETPT       7'h00
`define TCM_RST_CAL_LO      12'h000
`define TCM_RST_CAL_HI      12'hfff
`endif

// ===== shared/tcm_pkg.sv
`default_nettype none
package tcm_pkg;
  typedef enum logic [1:0] {
    TCM_MODE_IDLE = 2'h0,
    TCM_MODE_PCAL = 2'h1,
    TCM_MODE_CCAL = 2'h2,
    TCM_MODE_CTRL = 2'h3
  } tcm_mode_e;

  typedef enum logic [3:0] {
    TCM_ST_IDLE = 4'h1,
    TCM_ST_PCAL = 4'h2,
    TCM_ST_CCAL = 4'h4,
    TCM_ST_CTRL = 4'h8
  } tcm_state_e;
endpackage : tcm_pkg
`default_nettype wire

// ===== testbench/tcm_motor_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Throttle motor with two opposed position sensors
module tcm_motor_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        en_i,
  input  wire logic        pwm_i,
  input  wire logic        dir_i,
  output logic      [11:0] analog1_o,
  output logic      [11:0] analog2_o
);
  logic [11:0] pos_r;
  // Moves only while the bridge is on and the pulse is high
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pos_r <= 12'h400;
    end else if (en_i && pwm_i) begin
      pos_r <= dir_i ? pos_r + 12'h001 : pos_r - 12'h001;
    end
  end
  // Opposed tracks, so a swapped sensor pair is easy to see
  assign analog1_o = pos_r;
  assign analog2_o = 12'hfff - pos_r;
endmodule : tcm_motor_model
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Bench
module tb_top;
  logic        clk, rst_n, rd, wr, slot, pwr, fault;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, q, rnd;
  logic        wreq, en, pwm, dir, det;
  logic [1:0]  mode;
  logic [11:0] a1, a2;
  int          n_errors, comparisons, k;
  int          n_rise, exp_rise;
  logic        pwm_q;

  tcm_channel #(.CAL_PHASE_CYC(16)) tcm_channel_i (
    .ref_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .slot_occupied_i(slot),
    .ext_power_ok_i(pwr), .bridge_fault_i(fault), .analog1_i(a1), .analog2_i(a2),
    .bridge_en_o(en), .bridge_pwm_o(pwm), .bridge_dir_o(dir),
    .mode_status_o(mode), .module_detected_o(det));

  tcm_motor_model tcm_motor_model_i (
    .clk_i(clk), .rst_n_i(rst_n), .en_i(en), .pwm_i(pwm), .dir_i(dir),
    .analog1_o(a1), .analog2_o(a2));

  always #20 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // Control word: both enables set, mode request, capture and swap
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic sw, input logic cp);
    return {26'h0, m, cp, sw, 2'b11};
  endfunction : ctl

  function automatic logic [31:0] sat(input logic [6:0] v);
    return (v > 7'd100) ? 32'd100 : {25'h0, v};
  endfunction : sat

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon transfer; held until waitrequest is seen low at an edge
  // Only the watchdog ends a wait that never gets its answer
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #(40 * 20000);
    n_errors++;
    end_of_test();
  end

  initial begin
    clk = 0; rst_n = 0; rd = 0; wr = 0; addr = 0; wdata = 0;
    slot = 1; pwr = 1; fault = 0; n_errors = 0; comparisons = 0; rnd = 32'd12;
    cyc(12);
    rst_n <= 1'b1;
    // Reset values and the unmapped place
    bus(0, 5'h00, 0); chk(q, 32'h0);
    bus(0, 5'h08, 0); chk(q, 32'h3e8);
    bus(0, 5'h14, 0); chk(q, 32'h0fff0000);
    bus(1, 5'h1c, 32'h5a5a5a5a); bus(0, 5'h1c, 0); chk(q, 32'h0);
    // Detection and bridge gating
    bus(1, 5'h00, 32'h2); cyc(4); chk({det, en}, 2'b10);
    bus(1, 5'h00, ctl(0, 0, 0)); cyc(4); chk({det, en}, 2'b11);
    pwr <= 1'b0; cyc(5); chk({det, en}, 2'b00);
    pwr <= 1'b1; cyc(5); fault <= 1'b1; cyc(5); chk({det, en}, 2'b10);
    fault <= 1'b0; cyc(5); chk(en, 1'b1);
    // Sensor roles, applied only by a capture
    bus(1, 5'h00, ctl(0, 0, 1)); bus(1, 5'h00, ctl(0, 0, 0));
    bus(0, 5'h18, 0); chk(q, {4'h0, a2, 4'h0, a1});
    bus(1, 5'h00, ctl(0, 1, 0)); bus(0, 5'h04, 0); chk(q[4], 1'b0);
    bus(1, 5'h00, ctl(0, 1, 1)); bus(1, 5'h00, ctl(0, 1, 0));
    bus(0, 5'h04, 0); chk(q[4], 1'b1);
    bus(0, 5'h18, 0); chk(q, {4'h0, a1, 4'h0, a2});
    bus(1, 5'h00, ctl(0, 0, 1)); bus(1, 5'h00, ctl(0, 0, 0));
    // Idle keeps the motor unpowered
    for (k = 0; k < 20; k++) begin
      @(posedge clk); chk(pwm, 1'b0);
    end
    bus(0, 5'h18, 0); chk(q[11:0], a1);
    // Control calibration falls straight back
    bus(1, 5'h00, ctl(2, 0, 0)); cyc(3); chk(mode, 2'd0);
    bus(0, 5'h04, 0); chk(q[1:0], 2'd0);
    // Position calibration repeats, idle aborts at once
    bus(1, 5'h00, ctl(0, 0, 0)); bus(1, 5'h00, ctl(1, 0, 0)); cyc(2);
    chk(mode, 2'd1);
    cyc(80); chk(mode, 2'd1);
    // Fixed calibration duty: one pulse per PWM period at the set rate
    bus(1, 5'h08, 32'd50000);
    n_rise = 0;
    pwm_q = pwm;
    for (k = 0; k < 2000; k++) begin
      @(posedge clk);
      if (pwm && !pwm_q) begin
        n_rise++;
      end
      pwm_q = pwm;
    end
    exp_rise = 2000 / (25000000 / 50000);
    chk(n_rise >= exp_rise - 1 && n_rise <= exp_rise + 1, 1'b1);
    chk(mode, 2'd1);
    bus(1, 5'h00, ctl(0, 0, 0)); cyc(2); chk(mode, 2'd0);
    // Control request waits for the pass to end
    bus(1, 5'h00, ctl(1, 0, 0)); bus(1, 5'h00, ctl(3, 0, 0)); cyc(3);
    chk(mode, 2'd1);
    k = 0;
    while (mode !== 2'd3 && k < 40) begin
      @(posedge clk); k++;
    end
    chk(mode, 2'd3);
    // Control cannot move to either calibration mode
    bus(1, 5'h00, ctl(1, 0, 0)); cyc(3); chk(mode, 2'd3);
    bus(1, 5'h00, ctl(2, 0, 0)); cyc(3); chk(mode, 2'd3);
    bus(0, 5'h00, 0); chk(q[5:4], 2'd2);
    // Setpoint stored as a percentage, random values with the top corner
    bus(1, 5'h0c, 32'd127); bus(0, 5'h0c, 0); chk(q, 32'd100);
    for (k = 0; k < 8; k++) begin
      rnd = xs(rnd);
      bus(1, 5'h0c, {25'h0, rnd[6:0]}); bus(0, 5'h0c, 0);
      chk(q, sat(rnd[6:0]));
      cyc(10); chk(mode, 2'd3);
    end
    bus(1, 5'h00, ctl(0, 0, 0)); cyc(2); chk(mode, 2'd0);
    cyc(3); chk(pwm, 1'b0);
    // Inverted captured range forces the clamp, whatever the sweep saw
    bus(1, 5'h10, 32'h00000fff);
    bus(1, 5'h00, ctl(0, 0, 1)); bus(1, 5'h00, ctl(0, 0, 0));
    bus(1, 5'h00, ctl(1, 0, 0)); cyc(40);
    bus(0, 5'h14, 0); chk(q, 32'h00000fff);
    bus(1, 5'h00, ctl(0, 0, 0)); cyc(2); chk(mode, 2'd0);
    bus(0, 5'h18, 0); chk(q[11:0], 12'h000);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
